//--- rtl/lurc_defines.svh
// Constants for the line unit mode and rate control block.
// Assumes inclusion by bare name from files under rtl/ and tb/.
`ifndef LURC_DEFINES_SVH
`define LURC_DEFINES_SVH

// Command register addresses on the serial port
`define LURC_ADDR_CR1       6'h01
`define LURC_ADDR_CR2       6'h02
`define LURC_ADDR_CR4       6'h04

// Register width and reset value
`define LURC_REG_W          5
`define LURC_REG_RST        5'h00

// Transmit control register fields
`define LURC_CR1_SINGLE     0
`define LURC_CR1_BUILD      1
`define LURC_CR1_CLKINV     2
`define LURC_CR1_ALLONES    3
`define LURC_CR1_TX_DRIVER_OFF      4

// Receive control register fields
`define LURC_CR2_EQDIS      0
`define LURC_CR2_DLOSDIS    1
`define LURC_CR2_ALOSDIS    2
`define LURC_CR2_CODECDIS   3

// Rate and loopback register fields
`define LURC_CR4_RLB        0
`define LURC_CR4_LLB        1
`define LURC_CR4_E3         2
`define LURC_CR4_STS        3

// Serial frame layout: direction, six address bits, spare, eight data
`define LURC_DIR_BIT        0
`define LURC_ADDR_LSB       1
`define LURC_ADDR_MSB       6
`define LURC_HEAD_BITS      5'd8
`define LURC_FRAME_BITS     5'd16
`define LURC_CNT_ZERO       5'd0
`define LURC_CNT_ONE        5'd1

// Timing: clock period and longest falling edge to output valid
`define LURC_CLK_NS         40
`define LURC_T_SDO_VALID_NS 200
`define LURC_SDO_VALID_CYC  (`LURC_T_SDO_VALID_NS / `LURC_CLK_NS)

`endif

//--- rtl/lurc_pkg.sv
// Types shared by the line unit mode and rate control block.
// Assumes the defines header is compiled alongside.
package lurc_pkg;

    // Line rate; one code also steers recovery, shaping and loss criteria
    typedef enum logic [1:0] {
        LURC_RATE_DS3,
        LURC_RATE_STS1,
        LURC_RATE_E3
    } lurc_rate_t;

    // Serial port frame progress
    typedef enum logic [1:0] {
        LURC_SER_IDLE,
        LURC_SER_SHIFT,
        LURC_SER_DONE
    } lurc_ser_t;

endpackage

//--- rtl/lurc_sync.sv
// Two-flop synchroniser bank with edge detection per bit.
// Assumes inputs are asynchronous pins; outputs sit in the CLK domain.
`timescale 1ns/1ps
module lurc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  logic         clk,
    input  logic         rst_b,
    // Asynchronous pins
    input  logic [W-1:0] async_in,
    // Synchronised level and one-cycle edges
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    ////////////////////////////////////////////////////////////////////////
    // One chain per bit; the first flop feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta;   // First stage, metastable
            logic stab;   // Second stage, safe to use
            logic prev;   // Delayed copy for edges

            // Chain of three flops, reset to low
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    meta <= 1'b0;
                    stab <= 1'b0;
                    prev <= 1'b0;
                end else begin
                    meta <= async_in[i];
                    stab <= meta;
                    prev <= stab;
                end
            end

            assign level[i] = stab;
            assign rise[i]  = stab & ~prev;
            assign fall[i]  = ~stab & prev;
        end
    endgenerate

endmodule

//--- rtl/lurc_top.sv
// Mode, rate and codec control with the four-wire serial command port.
// Assumes all pins are asynchronous to CLK; the serial clock is slow
// enough (half periods of 160 ns or more) to be oversampled at 25 MHz.
//
// Overview of operation
// - Input bits captured on serial clock rise
// - Read output bit updated after falls 8 to 15
// - Output released after last fall or deselect
// - Strap low: port off, pins configure
// - Hardware mode reassigns the serial pins
// - Strap high: configuration from command registers
// - Host mode ignores the dedicated config pins
// - Pins: E3 wins, else DS3 or STS-1
// - Host rate from register four, E3 wins
// - Register four holds both loopback enables
// - Rate sets recovery, codec, shaping, loss
// - Mark is pulse, space is no pulse
// - Receiver decodes to rails plus two clocks
// - Transmit input single or dual rail
// - Register one bit zero selects single rail
// - Register two bit three disables codec
`timescale 1ns/1ps
`include "lurc_defines.svh"
module lurc_top
    import lurc_pkg::*;
(
    // Clock and synchronous active-low reset
    input  logic       CLK,
    input  logic       RST_B,
    // Mode strap and shared serial port pins
    input  logic       CONFIG_SOURCE_STRAP,
    input  logic       CHIP_SEL_B_OR_RAIL,
    input  logic       SCLK_OR_CODEC_DIS,
    input  logic       SDI_OR_MUTE_EN,
    input  logic       REG_CLEAR_B_OR_RX2_INV,
    output logic       SDO_OR_CV_OUT,
    output logic       SDO_OR_CV_OE,
    output logic       CV_OR_RX2_CLK,
    // Dedicated configuration pins, used in hardware mode only
    input  logic       TX_BUILD_OUT_LEVEL_PIN,
    input  logic       TX_ALL_ONES_PIN,
    input  logic       RX_EQ_DISABLE_PIN,
    input  logic       LOCAL_LOOPBACK_PIN,
    input  logic       REMOTE_LOOPBACK_PIN,
    input  logic       SONET_OR_T3_PIN,
    input  logic       EUROPEAN_RATE_PIN,
    input  logic       TX_DRIVER_OFF_PIN,
    // Status from the receive datapath
    input  logic       CODE_VIOLATION,
    input  logic       SECOND_RX_CLOCK,
    // Selects toward the datapaths
    output lurc_rate_t RATE_SEL,
    output logic       CODEC_HDB3,
    output logic       CODEC_DISABLE,
    output logic       TX_SINGLE_RAIL,
    output logic       TX_DRIVER_OFF,
    output logic       TX_ALL_ONES,
    output logic       TX_CLK_INVERT,
    output logic       TX_BUILD_OUT,
    output logic       RX_EQ_DISABLE,
    output logic       DIGITAL_LOS_DISABLE,
    output logic       ANALOG_LOS_DISABLE,
    output logic       LOCAL_LOOPBACK,
    output logic       REMOTE_LOOPBACK,
    output logic       LOS_MUTE_ENABLE,
    output logic       RX2_CLK_INVERT
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic       sclk_s;      // Serial clock level
    logic       sclk_rise;   // Serial clock rising edge
    logic       sclk_fall;   // Serial clock falling edge
    logic [13:0] pin_lvl;    // Other pins, synchronised
    logic       host_s, cs_b_s, sdi_s, clr_b_s, cv_s, rx2_s;
    logic       lev_s, aos_s, eq_s, llb_s, rlb_s, sts_s, e3_s, off_s;

    // Serial clock gets its own bank for edge detection
    lurc_sync #(.W(1)) u_sync_sclk (
        .clk      (CLK),
        .rst_b    (RST_B),
        .async_in (SCLK_OR_CODEC_DIS),
        .level    (sclk_s),
        .rise     (sclk_rise),
        .fall     (sclk_fall)
    );

    lurc_sync #(.W(14)) u_sync_pins (
        .clk      (CLK),
        .rst_b    (RST_B),
        .async_in ({CONFIG_SOURCE_STRAP, CHIP_SEL_B_OR_RAIL,
                    SDI_OR_MUTE_EN, REG_CLEAR_B_OR_RX2_INV,
                    CODE_VIOLATION, SECOND_RX_CLOCK,
                    TX_BUILD_OUT_LEVEL_PIN, TX_ALL_ONES_PIN,
                    RX_EQ_DISABLE_PIN, LOCAL_LOOPBACK_PIN,
                    REMOTE_LOOPBACK_PIN, SONET_OR_T3_PIN,
                    EUROPEAN_RATE_PIN, TX_DRIVER_OFF_PIN}),
        .level    (pin_lvl),
        .rise     (),
        .fall     ()
    );

    assign {host_s, cs_b_s, sdi_s, clr_b_s, cv_s, rx2_s,
            lev_s, aos_s, eq_s, llb_s, rlb_s, sts_s, e3_s, off_s} = pin_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Serial frame engine
    lurc_ser_t            state;   // Frame progress
    logic [4:0]           cnt;     // Rising edges seen in this frame
    logic [7:0]           head;    // Direction, address, spare
    logic [7:0]           wdata;   // Data bits shifted in
    logic [7:0]           rdata;   // Register image being shifted out
    logic [7:0]           rimage;  // Image of the addressed register
    logic                 sdo_bit; // Serial output bit
    logic                 sdo_oe;  // Serial output drive enable
    logic [`LURC_REG_W-1:0] cr1, cr2, cr4;   // Command registers
    logic                 port_on; // Port enabled and selected
    logic                 commit;  // Last write bit just taken
    logic [5:0]           addr;    // Decoded register address

    assign port_on = host_s & ~cs_b_s;
    assign addr    = head[`LURC_ADDR_MSB:`LURC_ADDR_LSB];
    assign commit  = port_on & sclk_rise & (state == LURC_SER_SHIFT) &
                     (cnt == `LURC_FRAME_BITS - `LURC_CNT_ONE) &
                     ~head[`LURC_DIR_BIT];

    // Read image of a register; unmapped addresses read as zero.
    // Top address bits are kept in the decode, so a host that breaks
    // the zero convention reaches nothing.
    function automatic logic [7:0] reg_image(input logic [5:0] a);
        reg_image = 8'h00;
        case (a)
            `LURC_ADDR_CR1: reg_image = {3'h0, cr1};
            `LURC_ADDR_CR2: reg_image = {3'h0, cr2};
            `LURC_ADDR_CR4: reg_image = {3'h0, cr4};
            default:        reg_image = 8'h00;
        endcase
    endfunction

    // Image of the addressed register, ready for the first read bit
    always_comb begin
        rimage = reg_image(addr);
    end

    // Frame state and bit capture
    always_ff @(posedge CLK) begin
        if (!RST_B || !port_on) begin
            // Deselect aborts any partial frame
            state <= LURC_SER_IDLE;
            cnt   <= `LURC_CNT_ZERO;
            head  <= 8'h00;
            wdata <= 8'h00;
        end else begin
            case (state)
                LURC_SER_IDLE: begin
                    state <= LURC_SER_SHIFT;
                end
                LURC_SER_SHIFT: begin
                    if (sclk_rise) begin
                        cnt <= cnt + `LURC_CNT_ONE;
                        if (cnt < `LURC_HEAD_BITS) begin
                            head <= {sdi_s, head[7:1]};
                        end else begin
                            wdata <= {sdi_s, wdata[7:1]};
                        end
                        if (cnt == `LURC_FRAME_BITS - `LURC_CNT_ONE) begin
                            state <= LURC_SER_DONE;
                        end
                    end
                end
                // Extra clocks after a full frame are ignored
                LURC_SER_DONE: state <= LURC_SER_DONE;
                default:       state <= LURC_SER_IDLE;
            endcase
        end
    end

    // Serial output: loads the image after the header, shifts on falls
    always_ff @(posedge CLK) begin
        if (!RST_B || !port_on) begin
            sdo_bit <= 1'b0;
            sdo_oe  <= 1'b0;
            rdata   <= 8'h00;
        end else if (sclk_fall && head[`LURC_DIR_BIT]) begin
            if (state == LURC_SER_SHIFT && cnt == `LURC_HEAD_BITS) begin
                // first data bit after falling edge
                sdo_bit <= rimage[0];
                rdata   <= rimage >> 1;
                sdo_oe  <= 1'b1;
            end else if (state == LURC_SER_SHIFT &&
                         cnt > `LURC_HEAD_BITS) begin
                // next bit on each falling edge
                sdo_bit <= rdata[0];
                rdata   <= rdata >> 1;
            end else if (state == LURC_SER_DONE) begin
                sdo_oe  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command registers, cleared by reset or the clear pin in host mode
    always_ff @(posedge CLK) begin
        if (!RST_B || (host_s && !clr_b_s)) begin
            cr1 <= `LURC_REG_RST;
            cr2 <= `LURC_REG_RST;
            cr4 <= `LURC_REG_RST;
        end else if (commit) begin
            // loopbacks and rate share one register
            // D0 to D4 sit in wdata[5:1] as the last bit arrives
            case (addr)
                `LURC_ADDR_CR1: cr1 <= wdata[5:1];
                `LURC_ADDR_CR2: cr2 <= wdata[5:1];
                `LURC_ADDR_CR4: cr4 <= wdata[5:1];
                default:        cr1 <= cr1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration source select
    lurc_rate_t next_rate;   // Rate from the active source

    // pins or register four, E3 overrides the other select
    always_comb begin
        next_rate = LURC_RATE_DS3;
        if (host_s ? cr4[`LURC_CR4_E3] : e3_s) begin
            next_rate = LURC_RATE_E3;
        end else if (host_s ? cr4[`LURC_CR4_STS] : sts_s) begin
            next_rate = LURC_RATE_STS1;
        end
    end

    // All selects are registered so the datapaths see clean levels
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            RATE_SEL            <= LURC_RATE_DS3;
            CODEC_HDB3          <= 1'b0;
            CODEC_DISABLE       <= 1'b0;
            TX_SINGLE_RAIL      <= 1'b0;
            TX_DRIVER_OFF       <= 1'b0;
            TX_ALL_ONES         <= 1'b0;
            TX_CLK_INVERT       <= 1'b0;
            TX_BUILD_OUT        <= 1'b0;
            RX_EQ_DISABLE       <= 1'b0;
            DIGITAL_LOS_DISABLE <= 1'b0;
            ANALOG_LOS_DISABLE  <= 1'b0;
            LOCAL_LOOPBACK      <= 1'b0;
            REMOTE_LOOPBACK     <= 1'b0;
            LOS_MUTE_ENABLE     <= 1'b0;
            RX2_CLK_INVERT      <= 1'b0;
        end else begin
            // one rate code steers all rate-bound parts
            // shaper marks ones by pulse per rate
            RATE_SEL   <= next_rate;
            CODEC_HDB3 <= (next_rate == LURC_RATE_E3);
            if (host_s) begin
                TX_SINGLE_RAIL      <= cr1[`LURC_CR1_SINGLE];
                TX_BUILD_OUT        <= cr1[`LURC_CR1_BUILD];
                TX_CLK_INVERT       <= cr1[`LURC_CR1_CLKINV];
                TX_ALL_ONES         <= cr1[`LURC_CR1_ALLONES];
                TX_DRIVER_OFF       <= cr1[`LURC_CR1_TX_DRIVER_OFF];
                RX_EQ_DISABLE       <= cr2[`LURC_CR2_EQDIS];
                DIGITAL_LOS_DISABLE <= cr2[`LURC_CR2_DLOSDIS];
                ANALOG_LOS_DISABLE  <= cr2[`LURC_CR2_ALOSDIS];
                CODEC_DISABLE       <= cr2[`LURC_CR2_CODECDIS];
                LOCAL_LOOPBACK      <= cr4[`LURC_CR4_LLB];
                REMOTE_LOOPBACK     <= cr4[`LURC_CR4_RLB];
                LOS_MUTE_ENABLE     <= 1'b0;
                RX2_CLK_INVERT      <= 1'b0;
            end else begin
                // select pin low means single rail
                TX_SINGLE_RAIL      <= ~cs_b_s;
                CODEC_DISABLE       <= sclk_s;
                LOS_MUTE_ENABLE     <= sdi_s;
                RX2_CLK_INVERT      <= clr_b_s;
                TX_BUILD_OUT        <= lev_s;
                TX_CLK_INVERT       <= 1'b0;
                TX_ALL_ONES         <= aos_s;
                TX_DRIVER_OFF       <= off_s;
                RX_EQ_DISABLE       <= eq_s;
                DIGITAL_LOS_DISABLE <= 1'b0;
                ANALOG_LOS_DISABLE  <= 1'b0;
                LOCAL_LOOPBACK      <= llb_s;
                REMOTE_LOOPBACK     <= rlb_s;
            end
        end
    end

    // Shared output pins; the violation flag loses two cycles to sync
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            SDO_OR_CV_OUT <= 1'b0;
            SDO_OR_CV_OE  <= 1'b0;
            CV_OR_RX2_CLK <= 1'b0;
        end else begin
            // flag and second clock in hardware mode
            SDO_OR_CV_OUT <= host_s ? sdo_bit : cv_s;
            SDO_OR_CV_OE  <= host_s ? sdo_oe : 1'b1;
            CV_OR_RX2_CLK <= host_s ? cv_s : rx2_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    int unsigned sdo_wait;   // Cycles since last serial clock fall
    always_ff @(posedge CLK) begin
        if (!RST_B || sclk_fall) begin
            sdo_wait <= 0;
        end else if (sdo_wait < 255) begin
            sdo_wait <= sdo_wait + 1;
        end
    end

    sequence s_last_rise;
        port_on && state == LURC_SER_SHIFT && sclk_rise &&
        cnt == `LURC_FRAME_BITS - `LURC_CNT_ONE;
    endsequence

    sequence s_last_fall;
        port_on && state == LURC_SER_DONE && sclk_fall;
    endsequence

    AST_SDO_AFTER_FALL: assert property (
        @(posedge CLK) disable iff (!RST_B)
        $changed(SDO_OR_CV_OUT) && SDO_OR_CV_OE && host_s && $past(host_s) |->
            sdo_wait < `LURC_SDO_VALID_CYC)
        else $error("serial output moved too long after a falling edge");

    AST_RELEASE_AT_END: assert property (
        @(posedge CLK) disable iff (!RST_B)
        s_last_fall |=> ##1 !SDO_OR_CV_OE || !$past(host_s))
        else $error("serial output still driven after final edge");

    AST_RELEASE_ON_DESELECT: assert property (
        @(posedge CLK) disable iff (!RST_B)
        host_s && cs_b_s |=> !sdo_oe)
        else $error("serial output driven while deselected");

    AST_CAPTURE_RISE: assert property (
        @(posedge CLK) disable iff (!RST_B)
        port_on && state == LURC_SER_SHIFT && sclk_rise |=>
            cnt == $past(cnt) + `LURC_CNT_ONE || !port_on)
        else $error("rising edge not counted");

    AST_WRITE_LANDS: assert property (
        @(posedge CLK) disable iff (!RST_B)
        s_last_rise ##0 (!head[`LURC_DIR_BIT] && addr == `LURC_ADDR_CR4
            && clr_b_s) |=> cr4 == $past(wdata[5:1]))
        else $error("rate register write lost");

    AST_HW_NO_WRITE: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !host_s |=> $stable(cr4) || $past(host_s))
        else $error("register changed in hardware mode");

    AST_HW_RATE_E3: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !host_s && e3_s |=> RATE_SEL == LURC_RATE_E3 && CODEC_HDB3)
        else $error("E3 pin did not select E3 with HDB3");

    AST_HOST_RATE: assert property (
        @(posedge CLK) disable iff (!RST_B)
        host_s && !cr4[`LURC_CR4_E3] && cr4[`LURC_CR4_STS] |=>
            RATE_SEL == LURC_RATE_STS1 && !CODEC_HDB3)
        else $error("register did not select STS-1");

    AST_HOST_IGNORES_PINS: assert property (
        @(posedge CLK) disable iff (!RST_B)
        host_s |=> TX_DRIVER_OFF == $past(cr1[`LURC_CR1_TX_DRIVER_OFF]) &&
            TX_SINGLE_RAIL == $past(cr1[`LURC_CR1_SINGLE]))
        else $error("host mode followed a dedicated pin");

    AST_HW_PIN_ROLES: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !host_s |=> SDO_OR_CV_OE && SDO_OR_CV_OUT == $past(cv_s) &&
            CODEC_DISABLE == $past(sclk_s))
        else $error("hardware pin roles not applied");

endmodule

//--- tb/lurc_host_model.sv
// Host processor model that drives the four-wire serial command port.
// Assumes CLK runs at 25 MHz; all pin changes land on its falling edge.
`timescale 1ns/1ps
module lurc_host_model #(
    parameter int HALF = 4   // Half serial period in clocks: 320 ns period
) (
    // Bench clock used as the host's time base
    input  wire logic clk,
    // Serial port pins toward the device
    output logic      cs_b,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    // Idle port: deselected, serial clock parked low between frames
    initial begin
        cs_b = 1'h1;
        sclk = 1'h0;
        sdi  = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One frame; stop below 16 aborts by deselecting mid-frame
    task automatic xfer(input logic rd, input logic [5:0] addr,
                        input logic [7:0] wd, input int stop,
                        output logic [7:0] rdata, output logic oe_ok);
        logic [15:0] fr;
        fr    = {wd, 1'h0, addr, rd};
        rdata = 8'h00;
        oe_ok = 1'h1;
        // select low ahead of first rise
        cs_b = 1'h0;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 16 && i != stop; i++) begin
            // data settles a half period before the rise
            sdi = fr[i];
            repeat (HALF) @(negedge clk);
            // Sample just before raising the clock, as a real host would
            if (i >= 8) begin
                rdata[i-8] = sdo;
            end
            oe_ok &= (sdo_oe === (rd && i >= 8));
            sclk = 1'h1;
            repeat (HALF) @(negedge clk);
            sclk = 1'h0;
        end
        repeat (6) @(negedge clk);
        oe_ok &= (sdo_oe === 1'h0);
        // Released data line shows the inverse, never the old value
        cs_b = 1'h1;
        sdi  = ~sdi;
        repeat (6) @(negedge clk);
    endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the mode, rate and serial command block.
// Assumes the package, defines header and host model are compiled first.
`timescale 1ns/1ps
`include "lurc_defines.svh"
module tb;
    import lurc_pkg::*;
    // Clock, reset, strap and plain inputs
    logic        CLK, RST_B, CONFIG_SOURCE_STRAP, REG_CLEAR_B_OR_RX2_INV;
    logic        CODE_VIOLATION, SECOND_RX_CLOCK;
    // Hardware mode pins and the shared serial pins
    logic [7:0]  pins;
    logic        hw_cs, hw_sclk, hw_sdi;
    wire         h_cs, h_sclk, h_sdi;
    wire         CHIP_SEL_B_OR_RAIL, SCLK_OR_CODEC_DIS, SDI_OR_MUTE_EN;
    wire         TX_DRIVER_OFF_PIN, EUROPEAN_RATE_PIN, SONET_OR_T3_PIN;
    wire         REMOTE_LOOPBACK_PIN, LOCAL_LOOPBACK_PIN, RX_EQ_DISABLE_PIN;
    wire         TX_ALL_ONES_PIN, TX_BUILD_OUT_LEVEL_PIN;
    // Design outputs
    lurc_rate_t  RATE_SEL;
    logic        SDO_OR_CV_OUT, SDO_OR_CV_OE, CV_OR_RX2_CLK, CODEC_HDB3;
    logic        CODEC_DISABLE, TX_SINGLE_RAIL, TX_DRIVER_OFF, TX_ALL_ONES;
    logic        TX_CLK_INVERT, TX_BUILD_OUT, RX_EQ_DISABLE, LOCAL_LOOPBACK;
    logic        DIGITAL_LOS_DISABLE, ANALOG_LOS_DISABLE, REMOTE_LOOPBACK;
    logic        LOS_MUTE_ENABLE, RX2_CLK_INVERT;
    // Bookkeeping and the bench's copy of the registers
    int          err_total, checks_done;
    logic [4:0]  c1, c2, c4;
    logic [7:0]  rd, wd;
    logic        ok;
    logic [18:0] act;

    // Serial pins belong to the host only while the strap selects it
    assign CHIP_SEL_B_OR_RAIL = CONFIG_SOURCE_STRAP ? h_cs : hw_cs;
    assign SCLK_OR_CODEC_DIS  = CONFIG_SOURCE_STRAP ? h_sclk : hw_sclk;
    assign SDI_OR_MUTE_EN     = CONFIG_SOURCE_STRAP ? h_sdi : hw_sdi;
    assign {TX_DRIVER_OFF_PIN, EUROPEAN_RATE_PIN, SONET_OR_T3_PIN,
            REMOTE_LOOPBACK_PIN, LOCAL_LOOPBACK_PIN, RX_EQ_DISABLE_PIN,
            TX_ALL_ONES_PIN, TX_BUILD_OUT_LEVEL_PIN} = pins;
    // Serial output is undefined in host mode outside reads: masked
    assign act = {RATE_SEL, CODEC_HDB3, CODEC_DISABLE, TX_SINGLE_RAIL,
                  TX_DRIVER_OFF, TX_ALL_ONES, TX_CLK_INVERT, TX_BUILD_OUT,
                  RX_EQ_DISABLE, DIGITAL_LOS_DISABLE, ANALOG_LOS_DISABLE,
                  LOCAL_LOOPBACK, REMOTE_LOOPBACK, LOS_MUTE_ENABLE,
                  RX2_CLK_INVERT, SDO_OR_CV_OE, CV_OR_RX2_CLK,
                  CONFIG_SOURCE_STRAP ? 1'h0 : SDO_OR_CV_OUT};

    lurc_top dut (.*);
    lurc_host_model host (.clk(CLK), .cs_b(h_cs), .sclk(h_sclk),
                          .sdi(h_sdi), .sdo(SDO_OR_CV_OUT),
                          .sdo_oe(SDO_OR_CV_OE));

    ////////////////////////////////////////////////////////////////////////
    // Expected outputs from the mode, the pins and the register copies
    function automatic logic [18:0] expect_outs(input logic hst);
        logic       e3;
        logic [1:0] r;
        e3 = hst ? c4[`LURC_CR4_E3] : pins[6];
        r  = e3 ? 2'h2 : ((hst ? c4[`LURC_CR4_STS] : pins[5]) ? 2'h1 : 2'h0);
        if (hst) begin
            return {r, e3, c2[3], c1[0], c1[4], c1[3], c1[2], c1[1], c2[0],
                    c2[1], c2[2], c4[1], c4[0], 3'h0, CODE_VIOLATION, 1'h0};
        end
        return {r, e3, hw_sclk, ~hw_cs, pins[7], pins[1], 1'h0, pins[0],
                pins[2], 2'h0, pins[3], pins[4], hw_sdi,
                REG_CLEAR_B_OR_RX2_INV, 1'h1, SECOND_RX_CLOCK, CODE_VIOLATION};
    endfunction

    // Compare tasks: one for output vectors, one for bytes and flags
    task automatic cmp_outs(input logic [18:0] got, input logic [18:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register access through the host model
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input int s);
        host.xfer(1'h0, a, d, s, rd, ok);
        cmp_byte({7'h00, ok}, 8'h01);
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        host.xfer(1'h1, a, 8'($urandom), 16, rd, ok);
        cmp_byte({7'h00, ok}, 8'h01);
        cmp_byte(rd, exp);
    endtask

    // Single exit point for the whole run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // 25 MHz clock and a watchdog well beyond the expected run
    initial begin
        CLK = 1'h0;
        forever #20 CLK = ~CLK;
    end
    initial begin
        repeat (30000) @(posedge CLK);
        err_total++;
        conclude();
    end

    // Main sequence
    initial begin
        void'($urandom(16));
        {RST_B, CONFIG_SOURCE_STRAP, CODE_VIOLATION, SECOND_RX_CLOCK} = 4'h0;
        {pins, hw_cs, hw_sclk, hw_sdi, c1, c2, c4} = 26'h0;
        REG_CLEAR_B_OR_RX2_INV = 1'h1;
        err_total   = 0;
        checks_done = 0;
        repeat (20) @(negedge CLK);
        cmp_outs(act, 19'h0); // outputs quiet under reset
        RST_B = 1'h1;
        // Hardware mode: random pins, every rate pin pair forced in turn
        for (int i = 0; i < 16; i++) begin
            {pins, hw_cs, hw_sclk, hw_sdi, REG_CLEAR_B_OR_RX2_INV,
             CODE_VIOLATION, SECOND_RX_CLOCK} = 14'($urandom);
            pins[6:5] = i[1:0];
            repeat (5) @(negedge CLK);
            cmp_outs(act, expect_outs(1'h0));
        end
        $display("test hardware_mode done");
        // Host mode: dedicated pins wiggle but must be ignored
        CONFIG_SOURCE_STRAP    = 1'h1;
        REG_CLEAR_B_OR_RX2_INV = 1'h1;
        repeat (5) @(negedge CLK);
        for (int k = 0; k < 4; k++) begin
            pins = 8'($urandom);
            wd = 8'($urandom);
            wd[3:2] = k[1:0];
            c4 = wd[4:0];
            wr(`LURC_ADDR_CR4, wd, 16);
            wd = 8'($urandom);
            c1 = wd[4:0];
            wr(`LURC_ADDR_CR1, wd, 16);
            wd = 8'($urandom);
            wd[3] = k[0];
            c2 = wd[4:0];
            wr(`LURC_ADDR_CR2, wd, 16);
            rdchk(`LURC_ADDR_CR4, {3'h0, c4});
            rdchk(`LURC_ADDR_CR1, {3'h0, c1});
            rdchk(`LURC_ADDR_CR2, {3'h0, c2});
            cmp_outs(act, expect_outs(1'h1));
        end
        $display("test host_registers done");
        // Unmapped places, top address bits set, and an aborted write
        wr(6'h24, 8'hFF, 16);
        wr(6'h03, 8'hFF, 16);
        wr(`LURC_ADDR_CR4, 8'h1F, 12);
        rdchk(6'h24, 8'h00);
        rdchk(6'h03, 8'h00);
        rdchk(`LURC_ADDR_CR4, {3'h0, c4});
        cmp_outs(act, expect_outs(1'h1));
        // Clear pin held low empties every register
        REG_CLEAR_B_OR_RX2_INV = 1'h0;
        repeat (5) @(negedge CLK);
        REG_CLEAR_B_OR_RX2_INV = 1'h1;
        {c1, c2, c4} = 15'h0;
        repeat (5) @(negedge CLK);
        cmp_outs(act, expect_outs(1'h1));
        $display("test host_refusals done");
        conclude();
    end
endmodule
